// ==== logic/system_clock_control_map.svh ====
// Register map, field positions and timing counts of the system clock control
`ifndef SYSTEM_CLOCK_CONTROL_MAP_SVH
`define SYSTEM_CLOCK_CONTROL_MAP_SVH
`define CLKDIV_CTRL_ADDR 8'h96
`define KEY_ADDR 8'hff
`define KEY_FIRST 8'haa
`define KEY_SECOND 8'h55
`define KEY_ARM_CYCLES 2'h3
`define KEY_OPEN_CYCLES 2'h3
`define CLKDIV_CTRL_RESET 8'h00
`define IRQ_MASK_BIT 7
`define UNLOCK_BIT 6
`define TOUCH_BIT 5
`define TEST_BIT 4
`define WARM_MAX 2'h0
`define WARM_XTAL_0 12'h800
`define WARM_XTAL_1 12'h400
`define WARM_XTAL_2 12'h100
`define WARM_XTAL_3 12'h040
`define WARM_RC_0 12'h400
`define WARM_RC_1 12'h100
`define WARM_RC_2 12'h040
`define WARM_RC_3 12'h008
`define WARM_EXT_0 12'h040
`define WARM_EXT_1 12'h008
`define WARM_EXT_2 12'h000
`define WARM_EXT_3 12'h000
`endif

// ==== logic/system_clock_control_pkg.sv ====
// Types shared by the system clock control
package system_clock_control_pkg;

    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'h0,
        SRC_CERAMIC = 2'h1,
        SRC_RC = 2'h2,
        SRC_EXTERNAL = 2'h3
    } clk_src_e;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'h0,
        KEY_ARMED = 2'h1,
        KEY_OPEN = 2'h2
    } key_state_e;

    typedef struct packed {
        key_state_e key_state;
        logic [1:0] key_cnt;
        logic [7:0] ctrl;
        logic [9:0] ratio;
        logic [8:0] div_cnt;
        logic osc_prev;
        logic sys_level;
        logic sys_tick;
        logic cpu_tick;
        logic per_tick;
        logic warm_busy;
        logic [11:0] warm_cnt;
        logic stop_prev;
        logic pin_out;
        logic slow_clk;
        logic [7:0] rdata;
    } clk_state_s;

endpackage : system_clock_control_pkg

// ==== logic/system_clock_control.sv ====
// System clock source select, prescaler, gating and protected divider register
`timescale 1ns/1ps
`include "system_clock_control_map.svh"

module system_clock_control (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    // Configuration words
    input wire logic [1:0] cfg_clk_src,
    input wire logic cfg_warm_valid,
    input wire logic [1:0] cfg_warm,
    input wire logic cfg_clkout_en,
    input wire logic cfg_wdt_valid,
    // Oscillator levels
    input wire logic xtal_osc,
    input wire logic rc_osc,
    input wire logic oscillator_input_pin,
    input wire logic sub_oscillator_clock,
    // Power modes
    input wire logic idle_mode,
    input wire logic stop_mode,
    input wire logic sleep_mode,
    input wire logic eeprom_busy,
    input wire logic watchdog_enable_bit,
    // Derived clocks
    output logic sys_clk,
    output logic sys_clk_tick,
    output logic cpu_clk_tick,
    output logic per_clk_tick,
    output logic osc_ready,
    output logic slow_clk,
    // Oscillator controls
    output logic xtal_osc_run,
    output logic rc_osc_run,
    output logic sub_osc_run,
    output logic oscillator_output_pin_release,
    // Clock output pin
    output logic clock_output_port_pin_out,
    output logic clock_output_port_pin_oe_n,
    // Control outputs
    output logic touch_key_detection,
    output logic irq_mask
);

    system_clock_control_pkg::clk_state_s s;
    system_clock_control_pkg::clk_state_s next_s;

    logic sel_osc;
    logic osc_rise;
    logic win_open;
    logic key_wr;
    logic ctrl_wr;
    logic deep_sleep;
    logic div_wrap;
    logic [11:0] warm_need;
    logic [1:0] warm_code;

    function automatic logic [9:0] ratio_of(input logic [3:0] code);
        case (code)
            4'h0: ratio_of = 10'h001;
            4'h1: ratio_of = 10'h002;
            4'h2: ratio_of = 10'h003;
            4'h3: ratio_of = 10'h004;
            4'h4: ratio_of = 10'h006;
            4'h5: ratio_of = 10'h008;
            4'h6: ratio_of = 10'h00c;
            4'h7: ratio_of = 10'h010;
            4'h8: ratio_of = 10'h018;
            4'h9: ratio_of = 10'h020;
            4'ha: ratio_of = 10'h030;
            4'hb: ratio_of = 10'h040;
            4'hc: ratio_of = 10'h060;
            4'hd: ratio_of = 10'h080;
            4'he: ratio_of = 10'h100;
            default: ratio_of = 10'h200;
        endcase
    endfunction : ratio_of

    function automatic logic [11:0] warm_of(input logic [1:0] src, input logic [1:0] code);
        logic [47:0] row;
        row = {`WARM_XTAL_3, `WARM_XTAL_2, `WARM_XTAL_1, `WARM_XTAL_0};
        if (src == system_clock_control_pkg::SRC_RC) begin
            row = {`WARM_RC_3, `WARM_RC_2, `WARM_RC_1, `WARM_RC_0};
        end else if (src == system_clock_control_pkg::SRC_EXTERNAL) begin
            row = {`WARM_EXT_3, `WARM_EXT_2, `WARM_EXT_1, `WARM_EXT_0};
        end
        warm_of = row[code*12 +: 12];
    endfunction : warm_of

    // Source select and oscillator enables
    always_comb begin
        case (cfg_clk_src)
            system_clock_control_pkg::SRC_RC: sel_osc = rc_osc;
            system_clock_control_pkg::SRC_EXTERNAL: sel_osc = oscillator_input_pin;
            default: sel_osc = xtal_osc;
        endcase
    end

    assign deep_sleep = stop_mode | sleep_mode;
    assign osc_rise = sel_osc & ~s.osc_prev;
    assign xtal_osc_run = ~cfg_clk_src[1] & ~deep_sleep;
    // EEPROM writes are timed by the RC oscillator, so it outlives stop
    assign rc_osc_run = ((cfg_clk_src == system_clock_control_pkg::SRC_RC) & ~deep_sleep)
                        | eeprom_busy;
    assign sub_osc_run = ~stop_mode | (cfg_wdt_valid & watchdog_enable_bit);
    assign oscillator_output_pin_release =
        cfg_clk_src == system_clock_control_pkg::SRC_EXTERNAL;

    // Unconfigured warm-up falls back to the longest setting
    assign warm_code = cfg_warm_valid ? cfg_warm : `WARM_MAX;
    assign warm_need = warm_of(cfg_clk_src, warm_code);

    assign key_wr = sfr_we & (sfr_addr == `KEY_ADDR);
    assign ctrl_wr = sfr_we & (sfr_addr == `CLKDIV_CTRL_ADDR);
    assign win_open = s.key_state == system_clock_control_pkg::KEY_OPEN;
    assign div_wrap = osc_rise & ~s.warm_busy & ({1'b0, s.div_cnt} == s.ratio - 10'h001);

    always_comb begin
        next_s = s;
        next_s.osc_prev = sel_osc;
        next_s.stop_prev = stop_mode;
        next_s.sys_tick = 1'b0;
        next_s.cpu_tick = 1'b0;
        next_s.per_tick = 1'b0;
        next_s.slow_clk = sub_oscillator_clock & sub_osc_run;

        // Unlock sequence; key writes while open are ignored
        case (s.key_state)
            system_clock_control_pkg::KEY_IDLE: begin
                if (key_wr && sfr_wdata == `KEY_FIRST) begin
                    next_s.key_state = system_clock_control_pkg::KEY_ARMED;
                    next_s.key_cnt = 2'h0;
                end
            end
            system_clock_control_pkg::KEY_ARMED: begin
                if (key_wr && sfr_wdata == `KEY_SECOND) begin
                    next_s.key_state = system_clock_control_pkg::KEY_OPEN;
                    next_s.key_cnt = 2'h0;
                end else if (key_wr && sfr_wdata == `KEY_FIRST) begin
                    next_s.key_cnt = 2'h0;
                end else if (key_wr || s.key_cnt == `KEY_ARM_CYCLES - 2'h1) begin
                    next_s.key_state = system_clock_control_pkg::KEY_IDLE;
                end else begin
                    next_s.key_cnt = s.key_cnt + 2'h1;
                end
            end
            system_clock_control_pkg::KEY_OPEN: begin
                if (s.key_cnt == `KEY_OPEN_CYCLES - 2'h1) begin
                    next_s.key_state = system_clock_control_pkg::KEY_IDLE;
                end else begin
                    next_s.key_cnt = s.key_cnt + 2'h1;
                end
            end
            default: begin
                next_s.key_state = system_clock_control_pkg::KEY_IDLE;
            end
        endcase

        // Protected divider register
        if (ctrl_wr && win_open) begin
            next_s.ctrl[`IRQ_MASK_BIT] = sfr_wdata[`IRQ_MASK_BIT];
            next_s.ctrl[`UNLOCK_BIT] = sfr_wdata[`UNLOCK_BIT];
            next_s.ctrl[3:0] = sfr_wdata[3:0];
            // Touch and test bits take the write only if the unlock bit was already set; software keeps test at zero
            if (s.ctrl[`UNLOCK_BIT]) begin
                next_s.ctrl[`TOUCH_BIT] = sfr_wdata[`TOUCH_BIT];
                next_s.ctrl[`TEST_BIT] = sfr_wdata[`TEST_BIT];
            end
        end

        next_s.rdata = 8'h00;
        if (sfr_re && sfr_addr == `CLKDIV_CTRL_ADDR) begin
            next_s.rdata = s.ctrl;
        end

        // Warm-up after reset or stop wake-up, counted in oscillator edges
        if (s.stop_prev && !stop_mode) begin
            next_s.warm_busy = 1'b1;
            next_s.warm_cnt = 12'h000;
        end else if (s.warm_busy) begin
            if (s.warm_cnt >= warm_need) begin
                next_s.warm_busy = 1'b0;
                next_s.div_cnt = 9'h000;
                next_s.ratio = ratio_of(s.ctrl[3:0]);
            end else if (osc_rise) begin
                next_s.warm_cnt = s.warm_cnt + 12'h001;
            end
        end

        // Prescaler; the new ratio is taken only at a period boundary
        if (div_wrap) begin
            next_s.div_cnt = 9'h000;
            next_s.ratio = ratio_of(s.ctrl[3:0]);
            next_s.sys_tick = 1'b1;
            next_s.cpu_tick = ~(idle_mode | deep_sleep);
            next_s.per_tick = ~deep_sleep;
        end else if (osc_rise && !s.warm_busy) begin
            next_s.div_cnt = s.div_cnt + 9'h001;
        end

        // Divide by one passes the source level straight through
        if (next_s.ratio == 10'h001) begin
            next_s.sys_level = sel_osc & ~s.warm_busy;
        end else begin
            next_s.sys_level = ~s.warm_busy
                & ({1'b0, next_s.div_cnt} < {1'b0, next_s.ratio[9:1]});
        end
        next_s.pin_out = stop_mode ? 1'b1 : next_s.sys_level;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '{
                key_state: system_clock_control_pkg::KEY_IDLE,
                key_cnt: 2'h0,
                ctrl: `CLKDIV_CTRL_RESET,
                ratio: 10'h001,
                div_cnt: 9'h000,
                osc_prev: 1'b0,
                sys_level: 1'b0,
                sys_tick: 1'b0,
                cpu_tick: 1'b0,
                per_tick: 1'b0,
                warm_busy: 1'b1,
                warm_cnt: 12'h000,
                stop_prev: 1'b0,
                pin_out: 1'b1,
                slow_clk: 1'b0,
                rdata: 8'h00
            };
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata = s.rdata;
    assign sys_clk = s.sys_level;
    assign sys_clk_tick = s.sys_tick;
    assign cpu_clk_tick = s.cpu_tick;
    assign per_clk_tick = s.per_tick;
    assign osc_ready = ~s.warm_busy;
    assign slow_clk = s.slow_clk;
    assign clock_output_port_pin_out = s.pin_out;
    assign clock_output_port_pin_oe_n = ~cfg_clkout_en;
    assign touch_key_detection = s.ctrl[`TOUCH_BIT];
    assign irq_mask = s.ctrl[`IRQ_MASK_BIT] & win_open;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_key_pair;
        key_wr && sfr_wdata == `KEY_FIRST && !win_open
        ##1 key_wr && sfr_wdata == `KEY_SECOND;
    endsequence

    sequence s_window;
        win_open [*3] ##1 !win_open;
    endsequence

    property p_key_opens;
        s_key_pair |=> win_open;
    endproperty
    a_key_opens: assert property (p_key_opens) else $error("window did not open");

    property p_window_len;
        $rose(win_open) |-> s_window;
    endproperty
    a_window_len: assert property (p_window_len) else $error("window length wrong");

    property p_locked_write;
        ctrl_wr && !win_open |=> $stable(s.ctrl);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked write took");

    property p_upper_lock;
        ctrl_wr && win_open && !s.ctrl[`UNLOCK_BIT] |=> $stable(s.ctrl[5:4]);
    endproperty
    a_upper_lock: assert property (p_upper_lock) else $error("bits 5:4 changed");

    property p_low_write;
        ctrl_wr && win_open |=> s.ctrl[3:0] == $past(sfr_wdata[3:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("ratio write lost");

    property p_cpu_gate;
        idle_mode || deep_sleep |=> !cpu_clk_tick;
    endproperty
    a_cpu_gate: assert property (p_cpu_gate) else $error("cpu clock not gated");

    property p_per_gate;
        deep_sleep |=> !per_clk_tick;
    endproperty
    a_per_gate: assert property (p_per_gate) else $error("peripheral clock not gated");

    property p_per_idle;
        idle_mode && !deep_sleep |=> per_clk_tick == sys_clk_tick;
    endproperty
    a_per_idle: assert property (p_per_idle) else $error("peripheral stopped in idle");

    // Each period opens high, so a consumer never sees a tick in a low phase
    property p_tick_high;
        sys_clk_tick |-> sys_clk;
    endproperty
    a_tick_high: assert property (p_tick_high) else $error("tick outside high phase");

    property p_cpu_per;
        cpu_clk_tick |-> per_clk_tick && sys_clk_tick;
    endproperty
    a_cpu_per: assert property (p_cpu_per) else $error("cpu and peripheral differ");

    property p_clkout_stop;
        stop_mode ##1 stop_mode |-> clock_output_port_pin_out;
    endproperty
    a_clkout_stop: assert property (p_clkout_stop) else $error("clock pin low in stop");

    property p_rc_eeprom;
        eeprom_busy |-> rc_osc_run;
    endproperty
    a_rc_eeprom: assert property (p_rc_eeprom) else $error("rc stopped in programming");

    property p_sub_stop;
        stop_mode && !(cfg_wdt_valid && watchdog_enable_bit) |=> !slow_clk;
    endproperty
    a_sub_stop: assert property (p_sub_stop) else $error("sub clock ran in stop");

    property p_wake_warm;
        $fell(stop_mode) |=> !osc_ready ##1 !sys_clk_tick;
    endproperty
    a_wake_warm: assert property (p_wake_warm) else $error("no warm-up on wake");

    property p_ratio_hold;
        s.div_cnt != 9'h000 && !s.warm_busy |=> $stable(s.ratio) || $past(div_wrap);
    endproperty
    a_ratio_hold: assert property (p_ratio_hold) else $error("ratio changed mid period");

endmodule : system_clock_control

// ==== bench/clock_consumer_model.sv ====
// Oscillator source and clock consumer model that counts the derived ticks
`timescale 1ns/1ps
module clock_consumer_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Derived clocks from the block
    input wire logic sys_clk_tick,
    input wire logic cpu_clk_tick,
    input wire logic per_clk_tick,
    input wire logic count_clear,
    // Oscillator levels to the block
    output logic osc_level,
    output logic sub_level,
    // Tick counts seen by the consumers
    output logic [15:0] sys_count,
    output logic [15:0] cpu_count,
    output logic [15:0] per_count
);
    logic [2:0] sub_div;
    // Source moves off the sampling edge: one rise every two cycles
    always @(negedge clk) begin
        if (!nrst) begin
            osc_level <= 1'b0;
            sub_level <= 1'b0;
            sub_div <= 3'h0;
        end else begin
            osc_level <= ~osc_level;
            sub_div <= sub_div + 3'h1;
            if (sub_div == 3'h7) begin
                sub_level <= ~sub_level;
            end
        end
    end
    always @(posedge clk) begin
        if (!nrst || count_clear) begin
            sys_count <= 16'h0;
            cpu_count <= 16'h0;
            per_count <= 16'h0;
        end else begin
            sys_count <= sys_count + {15'h0, sys_clk_tick};
            cpu_count <= cpu_count + {15'h0, cpu_clk_tick};
            per_count <= per_count + {15'h0, per_clk_tick};
        end
    end
endmodule : clock_consumer_model

// ==== bench/system_clock_control_bench.sv ====
// Self-checking bench for the system clock control
`timescale 1ns/1ps
module system_clock_control_bench;
    logic clk, nrst, sfr_we, sfr_re, cfg_warm_valid, cfg_clkout_en, cfg_wdt_valid;
    logic idle_mode, stop_mode, sleep_mode, eeprom_busy, watchdog_enable_bit, count_clear;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0] cfg_clk_src, cfg_warm;
    logic osc_level, sub_level, sys_clk, sys_clk_tick, cpu_clk_tick, per_clk_tick;
    logic osc_ready, slow_clk, xtal_osc_run, rc_osc_run, sub_osc_run, out_release;
    logic pin_out, pin_oe_n, touch_key_detection, irq_mask;
    logic [15:0] sys_count, cpu_count, per_count;
    int num_errors = 0;
    int checked = 0;
    int ratio_tab [16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 256, 512};

    system_clock_control system_clock_control_inst (
        .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
        .cfg_clk_src(cfg_clk_src), .cfg_warm_valid(cfg_warm_valid), .cfg_warm(cfg_warm),
        .cfg_clkout_en(cfg_clkout_en), .cfg_wdt_valid(cfg_wdt_valid),
        .xtal_osc(osc_level), .rc_osc(osc_level), .oscillator_input_pin(osc_level),
        .sub_oscillator_clock(sub_level), .idle_mode(idle_mode), .stop_mode(stop_mode),
        .sleep_mode(sleep_mode), .eeprom_busy(eeprom_busy),
        .watchdog_enable_bit(watchdog_enable_bit), .sys_clk(sys_clk),
        .sys_clk_tick(sys_clk_tick), .cpu_clk_tick(cpu_clk_tick),
        .per_clk_tick(per_clk_tick), .osc_ready(osc_ready), .slow_clk(slow_clk),
        .xtal_osc_run(xtal_osc_run), .rc_osc_run(rc_osc_run), .sub_osc_run(sub_osc_run),
        .oscillator_output_pin_release(out_release),
        .clock_output_port_pin_out(pin_out), .clock_output_port_pin_oe_n(pin_oe_n),
        .touch_key_detection(touch_key_detection), .irq_mask(irq_mask)
    );

    clock_consumer_model clock_consumer_model_inst (
        .clk(clk), .nrst(nrst), .sys_clk_tick(sys_clk_tick), .cpu_clk_tick(cpu_clk_tick),
        .per_clk_tick(per_clk_tick), .count_clear(count_clear), .osc_level(osc_level),
        .sub_level(sub_level), .sys_count(sys_count), .cpu_count(cpu_count),
        .per_count(per_count)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task results();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Write strobe is left high so writes can run back to back
    task wr(input logic [7:0] addr, input logic [7:0] data);
        sfr_re = 1'b0;
        sfr_we = 1'b1;
        sfr_addr = addr;
        sfr_wdata = data;
        @(negedge clk);
    endtask : wr

    task gap();
        sfr_we = 1'b0;
        @(negedge clk);
    endtask : gap

    task rd(input logic [7:0] addr, input logic [7:0] exp);
        sfr_we = 1'b0;
        sfr_re = 1'b1;
        sfr_addr = addr;
        @(negedge clk);
        sfr_re = 1'b0;
        check({8'h0, sfr_rdata}, {8'h0, exp});
        @(negedge clk);
    endtask : rd

    task key();
        wr(8'hff, 8'haa);
        wr(8'hff, 8'h55);
    endtask : key

    task wait_ready();
        int i;
        for (i = 0; i < 400 && osc_ready !== 1'b1; i++) @(negedge clk);
        if (osc_ready !== 1'b1) begin
            num_errors++;
            results();
        end
    endtask : wait_ready

    task wait_tick();
        int i;
        for (i = 0; i < 2100 && sys_clk_tick !== 1'b1; i++) @(negedge clk);
        if (sys_clk_tick !== 1'b1) begin
            num_errors++;
            results();
        end
        check({15'h0, sys_clk}, 16'h1);
        @(negedge clk);
    endtask : wait_tick

    // Window of 9n cycles after a tick holds exactly four ticks
    task measure(input int n, input logic [15:0] ec, input logic [15:0] ep);
        wait_tick();
        wait_tick();
        count_clear = 1'b1;
        @(negedge clk);
        count_clear = 1'b0;
        repeat (9 * n - 1) @(negedge clk);
        check(sys_count, 16'h4);
        check(cpu_count, ec);
        check(per_count, ep);
    endtask : measure

    task quiet();
        count_clear = 1'b1;
        @(negedge clk);
        count_clear = 1'b0;
        repeat (40) @(negedge clk);
        check(cpu_count, 16'h0);
        check(per_count, 16'h0);
    endtask : quiet

    initial begin
        {nrst, sfr_we, sfr_re, sfr_addr, sfr_wdata, count_clear} = '0;
        {idle_mode, stop_mode, sleep_mode, eeprom_busy, watchdog_enable_bit} = '0;
        {cfg_warm_valid, cfg_warm, cfg_clkout_en, cfg_wdt_valid} = '0;
        cfg_clk_src = 2'h3;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (100) @(negedge clk);
        check({15'h0, osc_ready}, 16'h0);
        wait_ready();
        cfg_warm_valid = 1'b1;
        cfg_warm = 2'h3;
        rd(8'h96, 8'h00);
        rd(8'hff, 8'h00);
        wr(8'h96, 8'h0f);
        gap();
        rd(8'h96, 8'h00);
        key();
        repeat (3) gap();
        wr(8'h96, 8'h01);
        gap();
        rd(8'h96, 8'h00);
        key();
        repeat (2) gap();
        wr(8'h96, 8'h01);
        gap();
        rd(8'h96, 8'h01);
        key();
        wr(8'h96, 8'h70);
        gap();
        rd(8'h96, 8'h40);
        check({15'h0, touch_key_detection}, 16'h0);
        key();
        wr(8'h96, 8'he0);
        sfr_we = 1'b0;
        check({15'h0, irq_mask}, 16'h1);
        repeat (3) @(negedge clk);
        check({15'h0, irq_mask}, 16'h0);
        rd(8'h96, 8'he0);
        check({15'h0, touch_key_detection}, 16'h1);
        for (int c = 0; c < 16; c++) begin
            key();
            wr(8'h96, {4'h0, c[3:0]});
            gap();
            measure(ratio_tab[c], 16'h4, 16'h4);
        end
        key();
        wr(8'h96, 8'h01);
        gap();
        idle_mode = 1'b1;
        measure(2, 16'h0, 16'h4);
        idle_mode = 1'b0;
        sleep_mode = 1'b1;
        quiet();
        sleep_mode = 1'b0;
        cfg_clkout_en = 1'b1;
        cfg_wdt_valid = 1'b1;
        cfg_clk_src = 2'h2;
        stop_mode = 1'b1;
        @(negedge clk);
        check({15'h0, pin_oe_n}, 16'h0);
        check({15'h0, sub_osc_run}, 16'h0);
        check({15'h0, slow_clk}, 16'h0);
        watchdog_enable_bit = 1'b1;
        eeprom_busy = 1'b1;
        @(negedge clk);
        check({15'h0, sub_osc_run}, 16'h1);
        check({15'h0, slow_clk}, {15'h0, sub_level});
        check({15'h0, rc_osc_run}, 16'h1);
        eeprom_busy = 1'b0;
        quiet();
        check({15'h0, rc_osc_run}, 16'h0);
        check({15'h0, pin_out}, 16'h1);
        stop_mode = 1'b0;
        cfg_clkout_en = 1'b0;
        @(negedge clk);
        check({15'h0, osc_ready}, 16'h0);
        wait_ready();
        check({15'h0, pin_oe_n}, 16'h1);
        for (int s = 0; s < 4; s++) begin
            cfg_clk_src = s[1:0];
            @(negedge clk);
            check({15'h0, out_release}, {15'h0, s == 3});
            check({15'h0, xtal_osc_run}, {15'h0, s < 2});
        end
        results();
    end
endmodule : system_clock_control_bench
